// *** rtl/dpra_consts.vh ***
// Constants for the dual-port memory port controller
`ifndef DPRA_CONSTS_VH
`define DPRA_CONSTS_VH
`define DPRA_CLK_PERIOD_NS 25
`define DPRA_AW 10
`define DPRA_DW 8
// Pin timing, ns as printed
`define DPRA_ADDRESS_ACCESS_DELAY_NS 15
`define DPRA_OE_ACCESS_NS 10
`define DPRA_DATA_SETUP_NS 10
`define DPRA_ADDR_SETUP_END_NS 12
`define DPRA_ADDR_HOLD_NS 2
`define DPRA_ADDR_SETUP_START_NS 0
`define DPRA_PRIORITY_SETUP_TIME_NS 5
`define DPRA_BLOCKED_WRITE_EXTENSION_NS 13
`define DPRA_CONTENTION_ASSERT_DELAY_NS 15
`define DPRA_MAILBOX_SET_DELAY_NS 15
`define DPRA_MAILBOX_CLEAR_DELAY_NS 15
`define DPRA_HIZ_NS 10
// Cycle counts: least times round up, then one more cycle
`define DPRA_CYC_UP(ns) (((ns) + `DPRA_CLK_PERIOD_NS - 1) / `DPRA_CLK_PERIOD_NS + 1)
`define DPRA_CNT_W 3
`define DPRA_RD_CYC `DPRA_CYC_UP(`DPRA_ADDRESS_ACCESS_DELAY_NS)
`define DPRA_WR_CYC `DPRA_CYC_UP(`DPRA_ADDR_SETUP_END_NS)
`define DPRA_WH_CYC `DPRA_CYC_UP(`DPRA_BLOCKED_WRITE_EXTENSION_NS)
`define DPRA_HOLD_CYC `DPRA_CYC_UP(`DPRA_ADDR_HOLD_NS)
`define DPRA_HIZ_CYC `DPRA_CYC_UP(`DPRA_HIZ_NS)
`define DPRA_FLAG_CYC `DPRA_CYC_UP(`DPRA_MAILBOX_SET_DELAY_NS)
`define DPRA_SETUP_CYC `DPRA_CYC_UP(`DPRA_ADDR_SETUP_START_NS)
// Mailbox words
`define DPRA_MBOX_LEFT 10'h3FF
`define DPRA_MBOX_RIGHT 10'h3FE
`endif

// *** rtl/dpra_wait.v ***
// Cycle countdown timer
`timescale 1ns/1ps
`include "dpra_consts.vh"
module dpra_wait
(
    // Clock and reset
    input wire clk_sys,
    input wire rstn,
    // Load and status
    input wire load,
    input wire [`DPRA_CNT_W-1:0] count,
    output wire done
);
    reg [`DPRA_CNT_W-1:0] cnt_q;
    // Count down to zero after a load
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            cnt_q <= 3'h0;
        else if (load)
            cnt_q <= count;
        else if (cnt_q != 3'h0)
            cnt_q <= cnt_q - 3'h1;
    end
    // Plain compare: gating with load would loop through the caller's decode
    assign done = (cnt_q == 3'h0);
endmodule // dpra_wait

// *** rtl/dpra_host.v ***
// Host controller driving one port of the dual-port memory
//
// Function
// [R1] Write only while select and strobe low
// [R2] Data set up before write end, held
// [R3] Address set up before, held after write
// [R4] Read data valid after address access delay
// [R5] Output drive access and release delays
// [R6] Deselect powers the port down
// [R7] Contention flag low on address match
// [R8] Contention flag released on mismatch
// [R9] Contention flag low on select collision
// [R10] Win priority by presenting address early
// [R11] Hold blocked write past flag release
// [R12] Read data valid after flag release
// [R13] Priority write leaves other outputs steady
// [R14] Mailbox write sets opposite port flag
// [R15] Reading own mailbox clears flag
// [R16] Mailboxes at words 3FF and 3FE
// [R17] Contention pin open drain on master
// [R18] Keep write strobe high during reads
// [R19] Ties resolved with single winner
`timescale 1ns/1ps
`include "dpra_consts.vh"
module dpra_host
(
    // Clock and reset
    input wire clk_sys,
    input wire rstn,
    // User command port
    input wire cmd_valid,
    input wire cmd_write,
    input wire cmd_mbox,
    input wire [`DPRA_AW-1:0] cmd_addr,
    input wire [`DPRA_DW-1:0] cmd_wdata,
    output wire cmd_ready,
    output reg rsp_valid_q,
    output reg [`DPRA_DW-1:0] rsp_rdata_q,
    output reg rsp_blocked_q,
    // Port identity: high for the right port
    input wire port_is_right,
    // Memory port pins
    output reg sel_n_q,
    output reg wr_n_q,
    output reg oe_n_q,
    output reg [`DPRA_AW-1:0] addr_q,
    input wire [`DPRA_DW-1:0] data_i,
    output reg [`DPRA_DW-1:0] data_o_q,
    output reg data_oe_n_q,
    input wire busy_n,
    input wire mbox_flag_n,
    // Mailbox event to user
    output wire mbox_pending
);
    localparam S_IDLE = 3'h0;
    localparam S_SETUP = 3'h1;
    localparam S_RD = 3'h2;
    localparam S_WR = 3'h3;
    localparam S_WAIT_BUSY = 3'h4;
    localparam S_EXTEND = 3'h5;
    localparam S_END = 3'h6;

    // Timer loads, cut to the counter width on purpose
    localparam integer SETUP_I = `DPRA_SETUP_CYC;
    localparam integer RD_I = `DPRA_RD_CYC;
    localparam integer WR_I = `DPRA_WR_CYC;
    localparam integer WH_I = `DPRA_WH_CYC;
    localparam integer HOLD_I = `DPRA_HOLD_CYC;
    localparam integer HIZ_I = `DPRA_HIZ_CYC;
    localparam [`DPRA_CNT_W-1:0] SETUP_CYC = SETUP_I[`DPRA_CNT_W-1:0];
    localparam [`DPRA_CNT_W-1:0] RD_CYC = RD_I[`DPRA_CNT_W-1:0];
    localparam [`DPRA_CNT_W-1:0] WR_CYC = WR_I[`DPRA_CNT_W-1:0];
    localparam [`DPRA_CNT_W-1:0] WH_CYC = WH_I[`DPRA_CNT_W-1:0];
    localparam [`DPRA_CNT_W-1:0] HOLD_CYC = HOLD_I[`DPRA_CNT_W-1:0];
    localparam [`DPRA_CNT_W-1:0] HIZ_CYC = HIZ_I[`DPRA_CNT_W-1:0];

    reg [2:0] st_q;
    reg [2:0] st_d;
    reg is_wr_q;
    reg blocked_q;
    reg load;
    reg [`DPRA_CNT_W-1:0] load_val;
    wire done;

    assign cmd_ready = (st_q == S_IDLE);
    // Active-low mailbox flag from the device
    assign mbox_pending = !mbox_flag_n;

    // One shared timer serves every timed phase
    dpra_wait u_wait
    (
        .clk_sys(clk_sys),
        .rstn(rstn),
        .load(load),
        .count(load_val),
        .done(done)
    );

    // Next state and timer loads
    always @*
    begin
        st_d = st_q;
        load = 1'b0;
        load_val = 3'h0;
        case (st_q)
            S_IDLE:
            begin
                if (cmd_valid)
                begin
                    // [R3] address before write start
                    // [R10] address early for priority
                    st_d = S_SETUP;
                    load = 1'b1;
                    load_val = SETUP_CYC;
                end
            end
            S_SETUP:
            begin
                if (done)
                begin
                    st_d = is_wr_q ? S_WR : S_RD;
                    load = 1'b1;
                    load_val = is_wr_q ? WR_CYC : RD_CYC;
                end
            end
            S_RD:
            begin
                // [R4] wait access time
                // [R12] restart after busy release
                if (!busy_n)
                begin
                    load = 1'b1;
                    load_val = RD_CYC;
                end
                else if (done)
                begin
                    st_d = S_END;
                    load = 1'b1;
                    load_val = HIZ_CYC;
                end
            end
            S_WR:
            begin
                // [R11] blocked write waits flag
                if (!busy_n)
                    st_d = S_WAIT_BUSY;
                else if (done)
                begin
                    st_d = S_END;
                    load = 1'b1;
                    load_val = HOLD_CYC;
                end
            end
            S_WAIT_BUSY:
            begin
                if (busy_n)
                begin
                    // [R11] extend strobe after release
                    st_d = S_EXTEND;
                    load = 1'b1;
                    load_val = WH_CYC;
                end
            end
            S_EXTEND:
            begin
                if (done)
                begin
                    st_d = S_END;
                    load = 1'b1;
                    load_val = HOLD_CYC;
                end
            end
            S_END:
            begin
                if (done)
                    st_d = S_IDLE;
            end
            default:
                st_d = S_IDLE;
        endcase
    end

    // State, pins and response registers
    always @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            st_q <= S_IDLE;
            is_wr_q <= 1'b0;
            blocked_q <= 1'b0;
            sel_n_q <= 1'b1;
            wr_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            addr_q <= 10'h000;
            data_o_q <= 8'h00;
            data_oe_n_q <= 1'b1;
            rsp_valid_q <= 1'b0;
            rsp_rdata_q <= 8'h00;
            rsp_blocked_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            rsp_valid_q <= 1'b0;
            case (st_q)
                S_IDLE:
                begin
                    if (cmd_valid)
                    begin
                        is_wr_q <= cmd_write;
                        blocked_q <= 1'b0;
                        // [R16] mailbox word of the chosen side
                        if (cmd_mbox)
                        begin
                            // Left writes the right box, reads its own
                            if (cmd_write ^ port_is_right)
                                addr_q <= `DPRA_MBOX_RIGHT;
                            else
                                addr_q <= `DPRA_MBOX_LEFT;
                        end
                        else
                            addr_q <= cmd_addr;
                        data_o_q <= cmd_wdata;
                        // [R6] select powers the port up
                        sel_n_q <= 1'b0;
                        // [R18] strobe high for reads
                        wr_n_q <= 1'b1;
                    end
                end
                S_SETUP:
                begin
                    if (done)
                    begin
                        if (is_wr_q)
                        begin
                            // [R1] strobe low with select low
                            // [R2] data driven from write start
                            wr_n_q <= 1'b0;
                            data_oe_n_q <= 1'b0;
                        end
                        else
                            // [R5] output drive for the read
                            oe_n_q <= 1'b0;
                    end
                end
                S_RD:
                begin
                    if (!busy_n)
                        blocked_q <= 1'b1;
                    else if (done)
                    begin
                        // [R15] mailbox read clears own flag
                        rsp_rdata_q <= data_i;
                        oe_n_q <= 1'b1;
                        sel_n_q <= 1'b1;
                    end
                end
                S_WR, S_EXTEND:
                begin
                    if (st_q == S_WR && !busy_n)
                        blocked_q <= 1'b1;
                    else if (done)
                        // [R14] write end sets far flag
                        wr_n_q <= 1'b1;
                end
                S_END:
                begin
                    if (done)
                    begin
                        // [R3] address kept through hold
                        data_oe_n_q <= 1'b1;
                        sel_n_q <= 1'b1;
                        rsp_valid_q <= 1'b1;
                        rsp_blocked_q <= blocked_q;
                    end
                end
                default:
                begin
                end
            endcase
        end
    end
endmodule // dpra_host

// *** verification/dpra_checker.sv ***
// Pin-level assertions for the memory port controller
`timescale 1ns/1ps
module dpra_checker
(
    // Clock and reset
    input wire clk_sys,
    input wire rstn,
    // Memory port pins
    input wire sel_n_q,
    input wire wr_n_q,
    input wire oe_n_q,
    input wire [9:0] addr_q,
    input wire [7:0] data_o_q,
    input wire data_oe_n_q,
    input wire busy_n,
    input wire mbox_flag_n,
    input wire mbox_pending
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    // Strobe low then released
    sequence s_wr_end; !wr_n_q ##1 wr_n_q; endsequence
    property p_wr_sel; !wr_n_q |-> !sel_n_q; endproperty
    a_wr_sel: assert property (p_wr_sel) else $error("strobe without select");
    property p_rd_wr; !oe_n_q |-> wr_n_q; endproperty
    a_rd_wr: assert property (p_rd_wr) else $error("strobe low in read");
    property p_oe_sel; !oe_n_q |-> !sel_n_q; endproperty
    a_oe_sel: assert property (p_oe_sel) else $error("drive without select");
    property p_pulse; $fell(wr_n_q) |=> !wr_n_q; endproperty
    a_pulse: assert property (p_pulse) else $error("write pulse short");
    property p_hold; s_wr_end |-> !sel_n_q && $stable(addr_q); endproperty
    a_hold: assert property (p_hold) else $error("address not held");
    property p_data; s_wr_end |-> !data_oe_n_q; endproperty
    a_data: assert property (p_data) else $error("data not held");
    property p_blk; !wr_n_q && $rose(busy_n) |=> !wr_n_q; endproperty
    a_blk: assert property (p_blk) else $error("blocked write cut");
    property p_pend; mbox_pending == !mbox_flag_n; endproperty
    a_pend: assert property (p_pend) else $error("pending wrong");
    property p_addr_wr; !wr_n_q |-> $stable(addr_q); endproperty
    a_addr_wr: assert property (p_addr_wr) else $error("address moved in write");
    property p_wdata; !data_oe_n_q |-> $stable(data_o_q); endproperty
    a_wdata: assert property (p_wdata) else $error("write data moved");
    property p_nofight; !data_oe_n_q |-> oe_n_q; endproperty
    a_nofight: assert property (p_nofight) else $error("drive fight on data");
    property p_rd_addr; !oe_n_q |-> $stable(addr_q); endproperty
    a_rd_addr: assert property (p_rd_addr) else $error("address moved in read");
endmodule // dpra_checker

bind dpra_host dpra_checker u_chk (.clk_sys(clk_sys), .rstn(rstn), .sel_n_q(sel_n_q),
    .wr_n_q(wr_n_q), .oe_n_q(oe_n_q), .addr_q(addr_q), .data_o_q(data_o_q),
    .data_oe_n_q(data_oe_n_q),
    .busy_n(busy_n), .mbox_flag_n(mbox_flag_n), .mbox_pending(mbox_pending));

// *** verification/dpra_mem_model.sv ***
// Behavioural model of one port of the dual-port memory
`timescale 1ns/1ps
module dpra_mem_model
(
    // Port pins
    input wire sel_n,
    input wire wr_n,
    input wire oe_n,
    input wire [9:0] addr,
    input wire [7:0] data_o,
    input wire data_oe_n,
    input wire is_right,
    output wire [7:0] data_i,
    output wire busy_n,
    output wire mbox_flag_n,
    // Far port stimulus
    input wire busy_hold,
    input wire far_post
);
    reg [7:0] mem [0:1023];
    reg flag = 1'b0;
    wire [9:0] own_box = is_right ? 10'h3FE : 10'h3FF;
    wire wact = !sel_n && !wr_n;
    wire rd = !sel_n && !oe_n && wr_n;
    // write lands at its end, lost while blocked
    always @(negedge wact)
        if (!data_oe_n && busy_n)
            mem[addr] = data_o;
    assign #5 data_i = rd ? mem[addr] : ~mem[addr];
    assign #5 busy_n = !(busy_hold && !sel_n);
    always @(posedge far_post)
        flag = 1'b1;
    always @(posedge rd)
        if (addr == own_box)
            flag = 1'b0;
    assign #5 mbox_flag_n = !flag;
endmodule // dpra_mem_model

// *** verification/tb_dual_port_ram_arbitration.sv ***
// Testbench for the memory port controller
`timescale 1ns/1ps
module tb_dual_port_ram_arbitration;
    reg clk_sys = 1'b0;
    reg rstn = 1'b0;
    reg cmd_valid = 1'b0, cmd_write = 1'b0, cmd_mbox = 1'b0;
    reg [9:0] cmd_addr = 10'h000;
    reg [7:0] cmd_wdata = 8'h00;
    reg busy_hold = 1'b0, far_post = 1'b0;
    reg port_right = 1'b0;
    wire cmd_ready, rsp_valid_q, rsp_blocked_q, sel_n_q, wr_n_q, oe_n_q;
    wire data_oe_n_q, busy_n, mbox_flag_n, mbox_pending;
    wire [7:0] rsp_rdata_q, data_i, data_o_q;
    wire [9:0] addr_q;
    integer bad_count = 0;
    integer comparisons = 0;
    integer i;
    // Rows: write, address, write data, expected read
    reg [26:0] rows [0:5];
    always #12.5 clk_sys = ~clk_sys;
    dpra_host dut (.clk_sys(clk_sys), .rstn(rstn), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_mbox(cmd_mbox), .cmd_addr(cmd_addr),
        .cmd_wdata(cmd_wdata), .cmd_ready(cmd_ready), .rsp_valid_q(rsp_valid_q),
        .rsp_rdata_q(rsp_rdata_q), .rsp_blocked_q(rsp_blocked_q), .port_is_right(port_right),
        .sel_n_q(sel_n_q), .wr_n_q(wr_n_q), .oe_n_q(oe_n_q), .addr_q(addr_q),
        .data_i(data_i), .data_o_q(data_o_q), .data_oe_n_q(data_oe_n_q),
        .busy_n(busy_n), .mbox_flag_n(mbox_flag_n), .mbox_pending(mbox_pending));
    dpra_mem_model u_mem (.sel_n(sel_n_q), .wr_n(wr_n_q), .oe_n(oe_n_q), .addr(addr_q),
        .data_o(data_o_q), .data_oe_n(data_oe_n_q), .is_right(port_right), .data_i(data_i),
        .busy_n(busy_n), .mbox_flag_n(mbox_flag_n), .busy_hold(busy_hold),
        .far_post(far_post));
    task wrap_up;
        begin
            $display("comparisons %0d mismatches %0d", comparisons, bad_count);
            if (bad_count == 0 && comparisons > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask
    task chk8(input string nm, input [7:0] e, input [7:0] g);
        begin
            comparisons = comparisons + 1;
            if (g !== e)
            begin
                $display("wrong value %s expected %h seen %h", nm, e, g);
                bad_count = bad_count + 1;
            end
        end
    endtask
    task chk1(input string nm, input e, input g);
        chk8(nm, {7'h00, e}, {7'h00, g});
    endtask
    // One command, then a bounded wait for its answer
    task run(input w, input m, input [9:0] a, input [7:0] d);
        integer n;
        begin
            @(posedge clk_sys);
            cmd_valid <= 1'b1;
            cmd_write <= w;
            cmd_mbox <= m;
            cmd_addr <= a;
            cmd_wdata <= d;
            @(posedge clk_sys);
            cmd_valid <= 1'b0;
            #1;
            n = 0;
            while (rsp_valid_q !== 1'b1 && n < 300)
            begin
                @(posedge clk_sys);
                #1;
                n = n + 1;
            end
            if (n >= 300)
            begin
                bad_count = bad_count + 1;
                wrap_up;
            end
        end
    endtask
    initial
    begin
        #500000;
        bad_count = bad_count + 1;
        wrap_up;
    end
    initial
    begin
        rows[0] = {1'b1, 10'h005, 8'hA5, 8'h00};
        rows[1] = {1'b1, 10'h3FD, 8'h3C, 8'h00};
        rows[2] = {1'b0, 10'h005, 8'h00, 8'hA5};
        rows[3] = {1'b0, 10'h3FD, 8'h00, 8'h3C};
        rows[4] = {1'b1, 10'h000, 8'hFF, 8'h00};
        rows[5] = {1'b0, 10'h000, 8'h00, 8'hFF};
        repeat (3) @(posedge clk_sys);
        #1;
        chk1("sel_n in reset", 1'b1, sel_n_q);
        chk1("wr_n in reset", 1'b1, wr_n_q);
        chk1("ready in reset", 1'b1, cmd_ready);
        @(posedge clk_sys);
        rstn <= 1'b1;
        $display("reset test done");
        for (i = 0; i < 6; i = i + 1)
        begin
            run(rows[i][26], 1'b0, rows[i][25:16], rows[i][15:8]);
            if (!rows[i][26])
                chk8("read data", rows[i][7:0], rsp_rdata_q);
            chk1("not blocked", 1'b0, rsp_blocked_q);
        end
        $display("table test done");
        // Reset lands while a read is under way
        @(posedge clk_sys);
        cmd_valid <= 1'b1;
        cmd_write <= 1'b0;
        cmd_mbox <= 1'b0;
        cmd_addr <= 10'h005;
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        repeat (3) @(posedge clk_sys);
        rstn <= 1'b0;
        #1;
        chk1("oe_n mid reset", 1'b1, oe_n_q);
        chk1("sel_n mid reset", 1'b1, sel_n_q);
        chk1("ready mid reset", 1'b1, cmd_ready);
        @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        #1;
        chk1("no answer after reset", 1'b0, rsp_valid_q);
        run(1'b0, 1'b0, 10'h005, 8'h00);
        chk8("read after reset", 8'hA5, rsp_rdata_q);
        $display("mid-run reset test done");
        // Far port holds the word for ten cycles
        busy_hold <= 1'b1;
        fork
            run(1'b1, 1'b0, 10'h010, 8'h5A);
            begin
                repeat (10) @(posedge clk_sys);
                busy_hold <= 1'b0;
            end
        join
        chk1("blocked", 1'b1, rsp_blocked_q);
        run(1'b0, 1'b0, 10'h010, 8'h00);
        chk8("blocked write", 8'h5A, rsp_rdata_q);
        // Read held off by the far port, then released
        busy_hold <= 1'b1;
        fork
            run(1'b0, 1'b0, 10'h010, 8'h00);
            begin
                repeat (10) @(posedge clk_sys);
                busy_hold <= 1'b0;
            end
        join
        chk1("blocked read", 1'b1, rsp_blocked_q);
        chk8("read after release", 8'h5A, rsp_rdata_q);
        $display("contention test done");
        @(posedge clk_sys);
        far_post <= 1'b1;
        @(posedge clk_sys);
        far_post <= 1'b0;
        @(posedge clk_sys);
        #6;
        chk1("pending set", 1'b1, mbox_pending);
        run(1'b0, 1'b1, 10'h000, 8'h00);
        #20;
        chk1("pending clear", 1'b0, mbox_pending);
        run(1'b1, 1'b1, 10'h000, 8'h77);
        run(1'b0, 1'b0, 10'h3FE, 8'h00);
        chk8("far mailbox", 8'h77, rsp_rdata_q);
        $display("mailbox test done");
        // Same mailbox traffic seen from the right port
        port_right <= 1'b1;
        run(1'b1, 1'b1, 10'h000, 8'h66);
        run(1'b0, 1'b0, 10'h3FF, 8'h00);
        chk8("right far mailbox", 8'h66, rsp_rdata_q);
        @(posedge clk_sys);
        far_post <= 1'b1;
        @(posedge clk_sys);
        far_post <= 1'b0;
        @(posedge clk_sys);
        #6;
        chk1("right pending set", 1'b1, mbox_pending);
        run(1'b0, 1'b1, 10'h000, 8'h00);
        #20;
        chk1("right pending clear", 1'b0, mbox_pending);
        chk8("right own mailbox", 8'h77, rsp_rdata_q);
        $display("right port test done");
        wrap_up;
    end
endmodule // tb_dual_port_ram_arbitration
